// ===== rtl/sfs_pkg.sv
package sfs_pkg;
  // core clock and write-cycle timing
  localparam int MCLK_PERIOD_NS = 100;
  localparam int WRITE_CYCLE_NS = 50000;
  localparam int WRITE_CYCLE_CYC =
    (WRITE_CYCLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int CNT_W = 10;

  // command opcodes on the serial link
  localparam logic [7:0] CMD_RD_SR1     = 8'h05;
  localparam logic [7:0] CMD_RD_SR2     = 8'h35;
  localparam logic [7:0] CMD_WR_SR2     = 8'h31;
  localparam logic [7:0] CMD_RD_SR3     = 8'h15;
  localparam logic [7:0] CMD_WR_SR3     = 8'h11;
  localparam logic [7:0] CMD_RD_CFG     = 8'h45;
  localparam logic [7:0] CMD_WR_CFG     = 8'h41;
  localparam logic [7:0] CMD_RD_SEC     = 8'h2B;
  localparam logic [7:0] CMD_WIDE_ENTER = 8'hB7;

  // frame bit positions
  localparam logic [4:0] BIT_CMD_LAST  = 5'h07;
  localparam logic [4:0] BIT_DATA_LAST = 5'h0F;
  localparam logic [4:0] BIT_FRAME_END = 5'h10;

  // field positions
  localparam int SR1_BUSY_BIT   = 0;
  localparam int SR2_LOCK3_BIT  = 6;
  localparam int SR2_LOCK1_BIT  = 4;
  localparam int SR2_QUAD_BIT   = 1;
  localparam int SR3_DRV_HI     = 6;
  localparam int SR3_DRV_LO     = 5;
  localparam int CFG_WIDE_BIT   = 5;
  localparam int SEC_EFAIL_BIT  = 6;
  localparam int SEC_PFAIL_BIT  = 5;
  localparam int SEC_ESUSP_BIT  = 3;
  localparam int SEC_PSUSP_BIT  = 2;
  localparam int SEC_LOCKD_BIT  = 1;
  localparam int SEC_FACT_BIT   = 0;

  // writable masks and reset values
  localparam logic [7:0] SR2_WR_MASK = 8'hF2;
  localparam logic [7:0] SR3_WR_MASK = 8'h60;
  localparam logic [7:0] CFG_WR_MASK = 8'hDF;
  localparam logic [7:0] SR2_RESET   = 8'h00;
  localparam logic [7:0] SR3_RESET   = 8'h60;
  localparam logic [7:0] CFG_RESET   = 8'h00;

  // write-cycle engine states
  typedef enum logic [1:0] {
    SFS_IDLE = 2'b01,
    SFS_BUSY = 2'b10
  } sfs_state_t;
endpackage

// ===== rtl/sfs_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sfs_status_regs
(
  // core clock and reset
  input  wire  logic       mclk,
  input  wire  logic       reset_n,
  // serial link
  input  wire  logic       sclk,
  input  wire  logic       csN,
  input  wire  logic       mosi,
  output logic             misoOut,
  output logic             misoOeN,
  // array engine events and states
  input  wire  logic       eraseDone,
  input  wire  logic       eraseOk,
  input  wire  logic       progDone,
  input  wire  logic       progOk,
  input  wire  logic       eraseSuspended,
  input  wire  logic       progSuspended,
  input  wire  logic       otpLockdownIn,
  input  wire  logic       factoryLockIn,
  // controls towards the core
  output logic [2:0]       secPageLock,
  output logic             quadEnable,
  output logic [1:0]       driveStrength,
  output logic             wideAddress,
  output logic             otpWriteBlock,
  output logic             writeBusy
);
  import sfs_pkg::*;
  localparam int WrCycLast = WRITE_CYCLE_CYC - 1;

  // link side state
  logic [4:0] bitCnt_reg, bitCnt_next;
  logic [7:0] cmd_reg, cmd_next, data_reg, data_next;
  logic       cmdDone_reg, cmdDone_next, dataDone_reg, dataDone_next;
  logic       miso_reg, miso_next, misoOeN_reg, misoOeN_next;
  // core side state
  sfs_state_t       state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0]       pendCmd_reg, pendCmd_next, pendData_reg, pendData_next;
  logic [7:0]       sr2_reg, sr2_next, sr3_reg, sr3_next, cfg_reg, cfg_next;
  logic             eFail_reg, eFail_next, pFail_reg, pFail_next;
  logic             otpBlk_reg, otpBlk_next;
  logic             cs1_reg, cs2_reg, cs3_reg, csHigh_reg, csHigh_next;
  logic [7:0]       snSr1_reg, snSr2_reg, snSr3_reg, snCfg_reg, snSec_reg;
  logic             snBusy_reg;
  logic [7:0]       rdByte;
  logic             frameEnd, isRead;

  // bit counter cleared by deselect so every frame starts fresh
  always_comb begin
    bitCnt_next = bitCnt_reg + 5'(bitCnt_reg != BIT_FRAME_END);
  end

  always_ff @(posedge sclk or posedge csN) begin
    if (csN) begin
      bitCnt_reg <= 5'h00;
    end else begin
      bitCnt_reg <= bitCnt_next;
    end
  end

  // command and data capture; kept over deselect for the core to read
  always_comb begin
    cmd_next      = cmd_reg;
    data_next     = data_reg;
    // done flags drop on a frame's first bit and rise on the last bit of their byte
    cmdDone_next  = (cmdDone_reg && bitCnt_reg != 5'h00) ||
                    bitCnt_reg == BIT_CMD_LAST;
    dataDone_next = (dataDone_reg && bitCnt_reg != 5'h00) ||
                    bitCnt_reg == BIT_DATA_LAST;
    if (bitCnt_reg <= BIT_CMD_LAST) begin
      cmd_next = {cmd_reg[6:0], mosi};
    end else if (bitCnt_reg <= BIT_DATA_LAST) begin
      data_next = {data_reg[6:0], mosi};
    end
  end

  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_reg      <= 8'h00;
      data_reg     <= 8'h00;
      cmdDone_reg  <= 1'b0;
      dataDone_reg <= 1'b0;
    end else begin
      cmd_reg      <= cmd_next;
      data_reg     <= data_next;
      cmdDone_reg  <= cmdDone_next;
      dataDone_reg <= dataDone_next;
    end
  end

  // read data from the frozen snapshot; refused reads show no driver
  always_comb begin
    isRead  = 1'b1;
    rdByte  = 8'h00;
    unique case (cmd_reg)
      CMD_RD_SR1: rdByte = snSr1_reg;
      CMD_RD_SR2: rdByte = snSr2_reg;
      CMD_RD_SR3: rdByte = snSr3_reg;
      CMD_RD_CFG: rdByte = snCfg_reg;
      CMD_RD_SEC: rdByte = snSec_reg;
      default:    isRead = 1'b0;
    endcase
    isRead = isRead && !(snBusy_reg && cmd_reg != CMD_RD_SR1);
  end

  // shift out on falling edges, msb first, during the second byte
  always_comb begin
    miso_next    = 1'b0;
    misoOeN_next = 1'b1;
    if (bitCnt_reg > BIT_CMD_LAST && bitCnt_reg <= BIT_DATA_LAST &&
        isRead) begin
      miso_next    = rdByte[3'(3'h7 - bitCnt_reg[2:0])];
      misoOeN_next = 1'b0;
    end
  end

  always_ff @(negedge sclk or posedge csN) begin
    if (csN) begin
      miso_reg    <= 1'b0;
      misoOeN_reg <= 1'b1;
    end else begin
      miso_reg    <= miso_next;
      misoOeN_reg <= misoOeN_next;
    end
  end

  assign misoOut = miso_reg;
  assign misoOeN = misoOeN_reg;

  // select pin into the core; a change counts once stages two and three agree
  always_comb begin
    csHigh_next = (cs2_reg == cs3_reg) ? cs3_reg : csHigh_reg;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cs1_reg    <= 1'b1;
      cs2_reg    <= 1'b1;
      cs3_reg    <= 1'b1;
      csHigh_reg <= 1'b1;
    end else begin
      cs1_reg    <= csN;
      cs2_reg    <= cs1_reg;
      cs3_reg    <= cs2_reg;
      csHigh_reg <= csHigh_next;
    end
  end

  // link regs are quiet once select is high, so reading them is safe
  assign frameEnd = csHigh_next && !csHigh_reg;

  // write cycle engine and register bank
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    pendCmd_next  = pendCmd_reg;
    pendData_next = pendData_reg;
    sr2_next      = sr2_reg;
    sr3_next      = sr3_reg;
    cfg_next      = cfg_reg;
    unique case (state_reg)
      SFS_IDLE: begin
        if (frameEnd && cmdDone_reg) begin
          if (cmd_reg == CMD_WIDE_ENTER) begin
            cfg_next[CFG_WIDE_BIT] = 1'b1;
          end else if (dataDone_reg && (cmd_reg == CMD_WR_SR2 ||
                       cmd_reg == CMD_WR_SR3 || cmd_reg == CMD_WR_CFG)) begin
            pendCmd_next  = cmd_reg;
            pendData_next = data_reg;
            cnt_next      = CNT_W'(WRITE_CYCLE_CYC);
            state_next    = SFS_BUSY;
          end
        end
      end
      SFS_BUSY: begin
        // frames ending now are dropped; the value lands at cycle end
        cnt_next = cnt_reg - CNT_W'(1);
        if (cnt_reg == CNT_W'(1)) begin
          state_next = SFS_IDLE;
          if (pendCmd_reg == CMD_WR_SR2) begin
            sr2_next = (sr2_reg & ~SR2_WR_MASK) |
                       (pendData_reg & SR2_WR_MASK);
          end else if (pendCmd_reg == CMD_WR_SR3) begin
            sr3_next = (sr3_reg & ~SR3_WR_MASK) |
                       (pendData_reg & SR3_WR_MASK);
          end else begin
            cfg_next = (cfg_reg & ~CFG_WR_MASK) |
                       (pendData_reg & CFG_WR_MASK);
          end
        end
      end
    endcase
  end

  // fail flags follow the outcome of the latest operation of each kind
  always_comb begin
    eFail_next  = eraseDone ? !eraseOk : eFail_reg;
    pFail_next  = progDone ? !progOk : pFail_reg;
    otpBlk_next = otpLockdownIn;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg    <= SFS_IDLE;
      cnt_reg      <= '0;
      pendCmd_reg  <= 8'h00;
      pendData_reg <= 8'h00;
      sr2_reg      <= SR2_RESET;
      sr3_reg      <= SR3_RESET;
      cfg_reg      <= CFG_RESET;
      eFail_reg    <= 1'b0;
      pFail_reg    <= 1'b0;
      otpBlk_reg   <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      pendCmd_reg  <= pendCmd_next;
      pendData_reg <= pendData_next;
      sr2_reg      <= sr2_next;
      sr3_reg      <= sr3_next;
      cfg_reg      <= cfg_next;
      eFail_reg    <= eFail_next;
      pFail_reg    <= pFail_next;
      otpBlk_reg   <= otpBlk_next;
    end
  end

  // snapshot refreshed only while deselected, frozen during a frame
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      snSr1_reg  <= 8'h00;
      snSr2_reg  <= SR2_RESET;
      snSr3_reg  <= SR3_RESET;
      snCfg_reg  <= CFG_RESET;
      snSec_reg  <= 8'h00;
      snBusy_reg <= 1'b0;
    end else if (csHigh_reg && cs3_reg) begin
      snSr1_reg  <= {7'h00, state_reg == SFS_BUSY};
      snSr2_reg  <= sr2_reg;
      snSr3_reg  <= sr3_reg;
      snCfg_reg  <= cfg_reg;
      snSec_reg  <= {1'b0, eFail_reg, pFail_reg, 1'b0,
                     eraseSuspended, progSuspended,
                     otpLockdownIn, factoryLockIn};
      snBusy_reg <= state_reg == SFS_BUSY;
    end
  end

  // outputs straight from the register bits
  assign secPageLock   = sr2_reg[SR2_LOCK3_BIT:SR2_LOCK1_BIT];
  assign quadEnable    = sr2_reg[SR2_QUAD_BIT];
  assign driveStrength = sr3_reg[SR3_DRV_HI:SR3_DRV_LO];
  assign wideAddress   = cfg_reg[CFG_WIDE_BIT];
  assign otpWriteBlock = otpBlk_reg;
  assign writeBusy     = state_reg == SFS_BUSY;

  property p_write_starts_cycle;
    @(posedge mclk) disable iff (!reset_n)
      (state_reg == SFS_IDLE && frameEnd && cmdDone_reg && dataDone_reg &&
       cmd_reg == CMD_WR_SR2) |=> writeBusy ##0 $stable(sr2_reg);
  endproperty
  a_write_starts_cycle: assert property (p_write_starts_cycle)
    else $error("register write did not start a write cycle");
  property p_busy_length;
    @(posedge mclk) disable iff (!reset_n)
      $rose(writeBusy) |-> ##[WrCycLast:WrCycLast] writeBusy ##1 !writeBusy;
  endproperty
  a_busy_length: assert property (p_busy_length)
    else $error("busy did not last exactly one write cycle");
  property p_refuse_when_busy;
    @(posedge mclk) disable iff (!reset_n)
      (writeBusy && cnt_reg > CNT_W'(1) && frameEnd) |=>
        $stable(sr2_reg) && $stable(sr3_reg) && $stable(cfg_reg);
  endproperty
  a_refuse_when_busy: assert property (p_refuse_when_busy)
    else $error("a frame was accepted during the write cycle");
  property p_wide_sticky;
    @(posedge mclk) disable iff (!reset_n)
      wideAddress |=> wideAddress;
  endproperty
  a_wide_sticky: assert property (p_wide_sticky)
    else $error("wide-address flag was cleared by a write");
  property p_wide_enter;
    @(posedge mclk) disable iff (!reset_n)
      (!writeBusy && frameEnd && cmdDone_reg && cmd_reg == CMD_WIDE_ENTER)
        |=> wideAddress;
  endproperty
  a_wide_enter: assert property (p_wide_enter)
    else $error("wide-address command did not set the flag");
  property p_pfail_clear;
    @(posedge mclk) disable iff (!reset_n)
      (progDone && progOk) |=> !pFail_reg;
  endproperty
  a_pfail_clear: assert property (p_pfail_clear)
    else $error("program-fail flag not cleared on success");
  property p_efail_set;
    @(posedge mclk) disable iff (!reset_n)
      (eraseDone && !eraseOk) |=> eFail_reg;
  endproperty
  a_efail_set: assert property (p_efail_set)
    else $error("erase-fail flag not set on failure");
  property p_otp_block;
    @(posedge mclk) disable iff (!reset_n)
      otpLockdownIn |=> otpWriteBlock;
  endproperty
  a_otp_block: assert property (p_otp_block)
    else $error("lock-down did not block the OTP area");
  property p_lock_only_at_commit;
    @(posedge mclk) disable iff (!reset_n)
      $changed(secPageLock) |-> $past(writeBusy) && !writeBusy;
  endproperty
  a_lock_only_at_commit: assert property (p_lock_only_at_commit)
    else $error("page lock changed outside a write-cycle end");
endmodule
`default_nettype wire

// ===== dv/sfs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host end of the serial link; its clock stands low between frames
module sfs_host_model (
  // serial link
  output logic       sclk,
  output logic       csN,
  output logic       mosi,
  input  wire logic  misoOut,
  input  wire logic  misoOeN,
  // last byte read back, high flag if any bit went undriven
  output logic [7:0] rdByte,
  output logic       rdOeN
);
  event      got;
  logic      lastMiso = 1'h0;
  wire logic lvl;

  // no pull on the line: a released line shows the inverse level
  assign lvl = misoOeN ? ~lastMiso : misoOut;

  always @(posedge sclk) begin
    if (!misoOeN) lastMiso <= misoOut;
  end

  initial begin
    sclk = 1'h0;
    csN = 1'h1;
    mosi = 1'h0;
  end

  // one frame of nb bits at a 6 ns link period, read bits after the command
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat,
                      input logic rd, input int nb, input logic nt);
    logic [15:0] sh;
    sh = {cmd, dat};
    rdOeN = 1'h0;
    csN = 1'h0;
    #400;  // select settles before the first edge
    for (int i = 15; i > 15 - nb; i--) begin
      mosi = (rd && i < 8) ? ~mosi : sh[i];
      #3;
      sclk = 1'h1;
      if (rd && i < 8) begin
        rdByte[i] = lvl;
        rdOeN = rdOeN | misoOeN;
      end
      #3;
      sclk = 1'h0;
    end
    csN = 1'h1;
    mosi = ~mosi;  // released data line does not keep its value
    if (nt) -> got;
    #700;  // gap also lets the core act on the frame first
  endtask
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sfs_pkg::*;
  // core side inputs
  logic       mclk;
  logic       reset_n;
  logic       eraseDone, eraseOk, progDone, progOk;
  logic       eraseSuspended, progSuspended, otpLockdownIn, factoryLockIn;
  // link and outputs
  wire logic  sclk, csN, mosi;
  logic       misoOut, misoOeN, quadEnable, wideAddress;
  logic       otpWriteBlock, writeBusy;
  logic [2:0] secPageLock;
  logic [1:0] driveStrength;
  // scoreboard
  logic [8:0] expQ[$];
  logic [8:0] busyCnt, busyLen;
  int         miscompares, cmpCount;
  integer     seed = 32'hB466796E;

  sfs_status_regs uut (
    .mclk(mclk), .reset_n(reset_n), .sclk(sclk), .csN(csN), .mosi(mosi),
    .misoOut(misoOut), .misoOeN(misoOeN), .eraseDone(eraseDone),
    .eraseOk(eraseOk), .progDone(progDone), .progOk(progOk),
    .eraseSuspended(eraseSuspended), .progSuspended(progSuspended),
    .otpLockdownIn(otpLockdownIn), .factoryLockIn(factoryLockIn),
    .secPageLock(secPageLock), .quadEnable(quadEnable),
    .driveStrength(driveStrength), .wideAddress(wideAddress),
    .otpWriteBlock(otpWriteBlock), .writeBusy(writeBusy)
  );

  sfs_host_model host (
    .sclk(sclk), .csN(csN), .mosi(mosi), .misoOut(misoOut),
    .misoOeN(misoOeN), .rdByte(), .rdOeN()
  );

  always #50 mclk = ~mclk;

  // length of each write cycle, so a restarted cycle shows up
  always @(posedge mclk) begin
    busyCnt <= writeBusy ? busyCnt + 9'h001 : 9'h000;
    if (!writeBusy && busyCnt != 9'h000) busyLen <= busyCnt;
  end

  task automatic chk(input logic [8:0] act, input logic [8:0] exp);
    cmpCount++;
    if (act !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %0h, expected %0h", $time, act, exp);
    end
  endtask

  // each noted read takes the oldest expectation off the queue
  always @(host.got) begin
    logic [8:0] e;
    e = expQ.pop_front();
    if (e[8]) chk(9'(host.rdOeN), 9'h001);
    else chk({host.rdOeN, host.rdByte}, e);
  end

  task automatic rd(input logic [7:0] cmd, input logic [8:0] e);
    expQ.push_back(e);
    host.xfer(cmd, 8'h00, 1'h1, 16, 1'h1);
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d, input int nb);
    host.xfer(cmd, d, 1'h0, nb, 1'h0);
  endtask

  // accepted write: busy must already be readable on the next poll
  task automatic regWrite(input logic [7:0] cmd, input logic [7:0] d);
    wr(cmd, d, 16);
    host.xfer(CMD_RD_SR1, 8'h00, 1'h1, 16, 1'h0);
    chk({host.rdOeN, host.rdByte[SR1_BUSY_BIT]}, 9'h001);
    chk(9'(writeBusy), 9'h001);
  endtask

  // poll until clear; a hang counts as a mismatch
  task automatic waitIdle();
    for (int n = 0; n < 200; n++) begin
      host.xfer(CMD_RD_SR1, 8'h00, 1'h1, 16, 1'h0);
      if (host.rdOeN === 1'h0 && host.rdByte[SR1_BUSY_BIT] === 1'h0) begin
        chk(busyLen, 9'(WRITE_CYCLE_CYC));
        return;
      end
    end
    miscompares++;
    completeRun();
  endtask

  task automatic outcome(input logic ef, input logic pf);
    @(posedge mclk);
    {eraseDone, eraseOk, progDone, progOk} <= {1'h1, ~ef, 1'h1, ~pf};
    @(posedge mclk);
    {eraseDone, progDone} <= 2'h0;
  endtask

  task automatic completeRun();
    $display("comparisons %0d, mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    logic [7:0] r, s2, s3, c;
    {eraseDone, eraseOk, progDone, progOk} = 4'h0;
    {eraseSuspended, progSuspended, otpLockdownIn, factoryLockIn} = 4'h0;
    mclk = 1'h0;
    reset_n = 1'h0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'h1;
    repeat (5) @(posedge mclk);
    chk(9'(driveStrength), 9'h003);
    chk(9'({secPageLock, quadEnable, wideAddress}), 9'h000);
    rd(CMD_RD_CFG, {1'h0, CFG_RESET});
    s2 = SR2_RESET;
    s3 = SR3_RESET;
    // status two: a value then its complement, each lock both ways
    for (int k = 0; k < 2; k++) begin
      r = k ? ~r : 8'($random(seed));
      rd(CMD_RD_SR2, {1'h0, s2});
      s2 = (s2 & ~SR2_WR_MASK) | (r & SR2_WR_MASK);
      regWrite(CMD_WR_SR2, s2);
      wr(CMD_WR_SR2, ~s2, 16);
      rd(CMD_RD_SR2, 9'h100);
      waitIdle();
      chk(9'(secPageLock), 9'(s2[6:4]));
      chk(9'(quadEnable), 9'(s2[1]));
      rd(CMD_RD_SR2, {1'h0, s2});
    end
    // status three: every drive code, reserved bits carried over
    for (int k = 0; k < 4; k++) begin
      s3[6:5] = 2'(k) ^ 2'h2;
      regWrite(CMD_WR_SR3, s3);
      waitIdle();
      chk(9'(driveStrength), 9'(s3[6:5]));
      rd(CMD_RD_SR3, {1'h0, s3});
    end
    // a write frame cut short of its data byte is dropped
    wr(CMD_WR_SR3, ~s3, 15);
    chk(9'(writeBusy), 9'h000);
    rd(CMD_RD_SR3, {1'h0, s3});
    // config: the wide flag ignores writes, moves only by command
    c = 8'($random(seed)) | 8'h20;
    regWrite(CMD_WR_CFG, c);
    wr(CMD_WIDE_ENTER, 8'h00, 8);
    waitIdle();
    chk(9'(wideAddress), 9'h000);
    rd(CMD_RD_CFG, {1'h0, c & CFG_WR_MASK});
    wr(CMD_WIDE_ENTER, 8'h00, 8);
    chk(9'({wideAddress, writeBusy}), 9'h002);
    c = ~c & CFG_WR_MASK;
    regWrite(CMD_WR_CFG, c);
    waitIdle();
    rd(CMD_RD_CFG, {1'h0, c | 8'h20});
    // security byte: program fail set, then cleared by a good outcome; erase fail only set
    for (int k = 0; k < 4; k++) begin
      r = 8'($random(seed));
      r[6:5] = 2'(k);
      @(posedge mclk);
      {eraseSuspended, progSuspended, otpLockdownIn, factoryLockIn} <= r[3:0];
      outcome(r[6], r[5]);
      repeat (3) @(posedge mclk);
      chk(9'(otpWriteBlock), 9'(r[1]));
      rd(CMD_RD_SEC, {1'h0, r & 8'h6F});
    end
    chk(9'(expQ.size()), 9'h000);
    completeRun();
  end
endmodule
`default_nettype wire
